// ===== shared/fpm_pkg.sv
// Contract
// [R1] Line start begins 3.5 ms soft-start
// [R2] Soft-start caps on-time 12.5/25/50 percent
// [R3] Output above minimum during soft-start: PFM
// [R4] Fault retry only after supply recharge
// [R5] Start at 12 V, lockout at 6 V
// [R6] Soft-start end, normal output: CV PWM
// [R7] No aux signal for 20 pulses: shutdown
// [R8] Load below limit: constant-voltage regulation
// [R9] CC holds current regardless of voltage
// [R10] Load estimated per cycle; CC wins
// [R11] Output at 20 percent: stop, restart
// [R12] Persistent overload repeats as hiccup
// [R13] PWM at high power, PFM light load
// [R14] Sample aux each cycle into feedback
// [R15] On-time from line and feedback
// [R16] Line sense scaled 0.0043; regulation, UV/OV
// [R17] Constant 40 kHz in CV and CC
// [R18] Missing aux edge extends off; 75 us stop
// [R19] PFM below 10 percent load, back automatically
// [R20] No constant-current during soft-start
// [R21] Gate low in lockout, fault, restart wait
// [R22] Soft-start stages timed by clock counts
package fpm_pkg;
  localparam int CLK_HZ     = 200_000_000;
  localparam int CLK_PER_US = CLK_HZ / 1_000_000;
  localparam int SS1_US     = 500;
  localparam int SS2_US     = 1000;
  localparam int SS3_US     = 2000;
  localparam int SW_HZ      = 40_000;
  localparam int PMAX_US    = 75;
  localparam int SS1_CYC    = CLK_PER_US * SS1_US;
  localparam int SS2_CYC    = CLK_PER_US * SS2_US;
  localparam int SS3_CYC    = CLK_PER_US * SS3_US;
  localparam int SW_PER_CYC = CLK_HZ / SW_HZ;
  localparam int PMAX_CYC   = CLK_PER_US * PMAX_US;

  localparam int CW = 20;
  localparam int TW = 12;
  localparam int AW = 8;
  localparam int DW = 32;
  localparam int VW = 10;

  localparam logic [TW-1:0] ON_MAX     = TW'(SW_PER_CYC / 2);
  localparam int            SS1_SHR    = 3;
  localparam int            SS2_SHR    = 2;
  localparam int            SS3_SHR    = 1;
  localparam logic [TW-1:0] SAMPLE_DLY = 12'h0C8;
  localparam logic [4:0]    NO_AUX_LIM = 5'h14;
  localparam int            ERR_SHR    = 2;
  localparam int            LFF_SHR    = 3;
  localparam int            PFM_SHL    = 1;

  localparam logic [VW-1:0] FB_REF_DEF  = 10'h200;
  localparam int            COLL_PCT    = 20;
  localparam int            FBMIN_PCT   = 90;
  localparam int            FBOV_PCT    = 110;
  localparam logic [VW-1:0] FB_COLLAPSE = VW'(FB_REF_DEF * COLL_PCT / 100);
  localparam logic [VW-1:0] FB_MIN      = VW'(FB_REF_DEF * FBMIN_PCT / 100);
  localparam logic [VW-1:0] FB_OV       = VW'(FB_REF_DEF * FBOV_PCT / 100);
  localparam logic [VW-1:0] AUX_PRESENT = 10'h020;

  // Line pin volts per line volt, in parts per million
  localparam int            LINE_SCALE_PPM = 4300;
  localparam int            ADC_FS_MV      = 2500;
  localparam int            ADC_CODES      = 1024;
  localparam int            LINE_UV_MV     = 240;
  localparam int            LINE_OV_MV     = 1930;
  localparam logic [VW-1:0] LINE_UV  = VW'(LINE_UV_MV * ADC_CODES / ADC_FS_MV);
  localparam logic [VW-1:0] LINE_OV  = VW'(LINE_OV_MV * ADC_CODES / ADC_FS_MV);
  localparam logic [VW-1:0] LINE_NOM = 10'h180;

  localparam int            LOAD_SHR    = 10;
  localparam logic [TW-1:0] LOAD_NOM    = 12'h400;
  localparam int            PFM_PCT     = 10;
  localparam logic [TW-1:0] LOAD_ILIM   = LOAD_NOM;
  localparam logic [TW-1:0] LOAD_PFM_LO = TW'(LOAD_NOM * PFM_PCT / 100);
  localparam logic [TW-1:0] LOAD_PFM_HI = TW'(2 * LOAD_NOM * PFM_PCT / 100);

  localparam logic [AW-1:0] REG_CTRL  = 8'h00;
  localparam logic [AW-1:0] REG_REF   = 8'h04;
  localparam logic [AW-1:0] REG_STAT  = 8'h08;
  localparam logic [AW-1:0] REG_FAULT = 8'h0C;
  localparam logic [AW-1:0] REG_FB    = 8'h10;
  localparam logic [AW-1:0] REG_LOAD  = 8'h14;
  localparam logic [AW-1:0] REG_ON    = 8'h18;
  localparam int            CTRL_EN   = 0;
  localparam int            ST_STATE  = 0;
  localparam int            ST_MODE   = 4;
  localparam int            ST_GATE   = 7;
  localparam int            ST_SUPOK  = 8;

  localparam int FLT_W        = 5;
  localparam int FLT_COLLAPSE = 0;
  localparam int FLT_NOAUX    = 1;
  localparam int FLT_PMAX     = 2;
  localparam int FLT_LINE     = 3;
  localparam int FLT_OV       = 4;

  typedef enum logic [3:0] {
    ST_LOCK = 4'b0001,
    ST_SOFT = 4'b0010,
    ST_RUN  = 4'b0100,
    ST_HALT = 4'b1000
  } fpm_state_t;

  typedef enum logic [2:0] {
    MD_CV  = 3'b001,
    MD_CC  = 3'b010,
    MD_PFM = 3'b100
  } fpm_mode_t;
endpackage : fpm_pkg

// ===== rtl/fpm_sync.sv
`timescale 1ns/100ps
module fpm_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule : fpm_sync

// ===== rtl/fpm_seq_top.sv
`timescale 1ns/100ps
module fpm_seq_top #(
  parameter int SS1_LEN    = fpm_pkg::SS1_CYC,
  parameter int SS2_LEN    = fpm_pkg::SS2_CYC,
  parameter int SS3_LEN    = fpm_pkg::SS3_CYC,
  parameter int SW_PERIOD  = fpm_pkg::SW_PER_CYC,
  parameter int PERIOD_MAX = fpm_pkg::PMAX_CYC
) (
  // Clock and reset
  input  wire logic                  CLK,
  input  wire logic                  RST_B,
  // Register port
  input  wire logic [fpm_pkg::AW-1:0] ADDR,
  input  wire logic [fpm_pkg::DW-1:0] WR_DATA,
  input  wire logic                  WR_EN,
  input  wire logic                  RD_EN,
  output logic      [fpm_pkg::DW-1:0] RD_DATA,
  // Supply threshold comparators
  input  wire logic                  SUPPLY_START,
  input  wire logic                  SUPPLY_LOW,
  // Line and auxiliary sense
  input  wire logic                  LINE_START,
  input  wire logic [fpm_pkg::VW-1:0] LINE_LVL,
  input  wire logic [fpm_pkg::VW-1:0] AUX_LVL,
  input  wire logic                  AUX_CMP,
  // Power switch
  output logic                       GATE_DRV
);
  import fpm_pkg::*;

  localparam int SYW = 2 * VW + 4;

  logic             rst_meta;
  logic             rst_n;
  logic [SYW-1:0]   sy;
  logic             sup_start;
  logic             sup_low;
  logic             line_start;
  logic             aux_cmp;
  logic [VW-1:0]    line_lvl;
  logic [VW-1:0]    aux_lvl;

  fpm_state_t       state, next_state;
  fpm_mode_t        mode, next_mode;
  logic [CW-1:0]    ss_cnt, next_ss_cnt;
  logic [CW-1:0]    cyc_cnt, next_cyc_cnt;
  logic [TW-1:0]    on_cmd, next_on_cmd;
  logic [VW-1:0]    fb, next_fb;
  logic [TW-1:0]    load_est, next_load_est;
  logic             aux_seen, next_aux_seen;
  logic             aux_prev, next_aux_prev;
  logic [4:0]       no_aux, next_no_aux;
  logic             sup_ok, next_sup_ok;
  logic [FLT_W-1:0] fault, next_fault;
  logic             en, next_en;
  logic [VW-1:0]    ref_lvl, next_ref_lvl;
  logic             next_gate;
  logic [DW-1:0]    next_rd;

  logic [FLT_W-1:0] flt_set;
  logic [FLT_W-1:0] flt_clr;
  logic             aux_fall;
  logic             switching;
  logic [TW-1:0]    cap;
  logic [CW-1:0]    per;
  logic signed [10:0] err;
  logic signed [10:0] lff;
  logic signed [13:0] req;
  logic [TW-1:0]    on_lim;
  logic [TW-1:0]    on_cc;
  logic [21:0]      prod;
  logic             cyc_end;

  // Reset released through two flops, asserted at once
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  fpm_sync #(.W(SYW)) u_sync (
    .clk   (CLK),
    .rst_n (rst_n),
    .d     ({SUPPLY_START, SUPPLY_LOW, LINE_START, AUX_CMP, LINE_LVL, AUX_LVL}),
    .q     (sy)
  );

  assign sup_start  = sy[SYW-1];
  assign sup_low    = sy[SYW-2];
  assign line_start = sy[SYW-3];
  assign aux_cmp    = sy[SYW-4];
  assign line_lvl   = sy[2*VW-1:VW];
  assign aux_lvl    = sy[VW-1:0];

  always_comb begin
    next_state    = state;
    next_mode     = mode;
    next_ss_cnt   = ss_cnt;
    next_cyc_cnt  = cyc_cnt;
    next_on_cmd   = on_cmd;
    next_fb       = fb;
    next_load_est = load_est;
    next_aux_seen = aux_seen;
    next_aux_prev = aux_cmp;
    next_no_aux   = no_aux;
    next_en       = en;
    next_ref_lvl  = ref_lvl;
    next_gate     = 1'b0;
    next_rd       = '0;
    flt_set       = '0;
    flt_clr       = '0;

    if (WR_EN) begin
      if (ADDR == REG_CTRL) begin
        next_en = WR_DATA[CTRL_EN];
      end else if (ADDR == REG_REF) begin
        next_ref_lvl = WR_DATA[VW-1:0];
      end else if (ADDR == REG_FAULT) begin
        flt_clr = WR_DATA[FLT_W-1:0];
      end
    end

    if (RD_EN) begin
      if (ADDR == REG_CTRL) begin
        next_rd[CTRL_EN] = en;
      end else if (ADDR == REG_REF) begin
        next_rd[VW-1:0] = ref_lvl;
      end else if (ADDR == REG_STAT) begin
        next_rd[ST_STATE +: 4] = state;
        next_rd[ST_MODE +: 3]  = mode;
        next_rd[ST_GATE]       = GATE_DRV;
        next_rd[ST_SUPOK]      = sup_ok;
      end else if (ADDR == REG_FAULT) begin
        next_rd[FLT_W-1:0] = fault;
      end else if (ADDR == REG_FB) begin
        next_rd[VW-1:0] = fb;
      end else if (ADDR == REG_LOAD) begin
        next_rd[TW-1:0] = load_est;
      end else if (ADDR == REG_ON) begin
        next_rd[TW-1:0] = on_cmd;
      end
    end

    // Hysteretic supply lockout
    next_sup_ok = sup_ok;
    if (sup_low) begin
      next_sup_ok = 1'b0; // [R5]
    end else if (sup_start) begin
      next_sup_ok = 1'b1; // [R5]
    end

    aux_fall  = aux_prev & ~aux_cmp;
    switching = (state == ST_SOFT) || (state == ST_RUN);

    // Soft-start on-time ceiling per stage
    cap = ON_MAX;
    if (state == ST_SOFT) begin
      if (ss_cnt < CW'(SS1_LEN)) begin
        cap = ON_MAX >> SS1_SHR; // [R2]
      end else if (ss_cnt < CW'(SS1_LEN + SS2_LEN)) begin
        cap = ON_MAX >> SS2_SHR; // [R2]
      end else begin
        cap = ON_MAX >> SS3_SHR; // [R2]
      end
    end

    // PFM stretches the period; CV and CC keep the fixed one
    per = (mode == MD_PFM) ? CW'(SW_PERIOD << PFM_SHL) : CW'(SW_PERIOD); // [R13] [R17]

    // On-time from feedback error plus line feed-forward
    err = $signed({1'b0, ref_lvl}) - $signed({1'b0, fb});
    lff = $signed({1'b0, LINE_NOM}) - $signed({1'b0, line_lvl}); // [R16]
    req = $signed({2'b00, on_cmd}) + 14'(err >>> ERR_SHR) + 14'(lff >>> LFF_SHR); // [R15]
    if (req < 14'sd1) begin
      on_lim = TW'(1);
    end else if (req > $signed({2'b00, cap})) begin
      on_lim = cap;
    end else begin
      on_lim = req[TW-1:0];
    end

    // CC walks the on-time to hold the load estimate at the limit
    if (load_est > LOAD_ILIM) begin
      on_cc = (on_cmd > TW'(1)) ? on_cmd - TW'(1) : on_cmd; // [R9]
    end else begin
      on_cc = (on_lim > on_cmd) ? on_cmd + TW'(1) : on_lim;
    end

    prod    = 22'(on_cmd) * 22'(line_lvl);
    cyc_end = switching && (cyc_cnt >= per - CW'(1)) && aux_seen;

    case (state)
      ST_LOCK: begin
        if (en && sup_ok && line_start && line_lvl >= LINE_UV && line_lvl <= LINE_OV) begin
          next_state    = ST_SOFT; // [R1]
          next_mode     = MD_CV;
          next_ss_cnt   = '0;
          next_cyc_cnt  = '0;
          next_on_cmd   = TW'(1);
          next_aux_seen = 1'b0;
          next_no_aux   = '0;
          // Stale samples from the last run must not pick the mode
          next_fb       = '0;
          next_load_est = '0;
          next_gate     = 1'b1;
        end
      end
      ST_SOFT, ST_RUN: begin
        next_cyc_cnt = cyc_cnt + CW'(1);
        next_gate    = (cyc_cnt + CW'(1)) < CW'(on_cmd);
        if (cyc_cnt == CW'(on_cmd) + CW'(SAMPLE_DLY)) begin
          next_fb = aux_lvl; // [R14]
        end
        if (cyc_cnt >= CW'(on_cmd) && aux_fall) begin
          next_aux_seen = 1'b1;
        end
        if (state == ST_SOFT) begin
          next_ss_cnt = ss_cnt + CW'(1); // [R22]
          if (fb >= FB_MIN) begin
            next_state = ST_RUN; // [R3]
            next_mode  = MD_PFM; // [R3]
          end else if (ss_cnt >= CW'(SS1_LEN + SS2_LEN + SS3_LEN - 1)) begin
            next_state = ST_RUN; // [R1] [R6]
            next_mode  = MD_CV; // [R6]
          end
        end
        if (cyc_end) begin
          next_cyc_cnt  = '0;
          next_aux_seen = 1'b0;
          next_gate     = 1'b1;
          next_load_est = prod[LOAD_SHR +: TW]; // [R10]
          next_on_cmd   = on_lim; // [R8]
          if (state == ST_RUN) begin // [R20]
            if (load_est >= LOAD_ILIM || (mode == MD_CC && on_lim >= on_cmd)) begin
              next_mode   = MD_CC; // [R10]
              next_on_cmd = on_cc; // [R9]
            end else if (load_est < LOAD_PFM_LO) begin
              next_mode = MD_PFM; // [R19]
            end else if (mode == MD_PFM && load_est < LOAD_PFM_HI) begin
              next_mode = MD_PFM;
            end else begin
              next_mode = MD_CV; // [R8] [R19]
            end
            next_no_aux = (fb < AUX_PRESENT) ? no_aux + 5'h01 : '0;
            if (fb < AUX_PRESENT && no_aux + 5'h01 >= NO_AUX_LIM) begin
              flt_set[FLT_NOAUX] = 1'b1; // [R7]
            end
            // Absent aux is the no-aux fault, not a collapse
            if (fb <= FB_COLLAPSE && fb >= AUX_PRESENT) begin
              flt_set[FLT_COLLAPSE] = 1'b1; // [R11]
            end
            if (fb > FB_OV) begin
              flt_set[FLT_OV] = 1'b1;
            end
          end
        end else if (cyc_cnt >= CW'(PERIOD_MAX - 1)) begin
          flt_set[FLT_PMAX] = 1'b1; // [R18]
        end
        if (line_lvl < LINE_UV || line_lvl > LINE_OV) begin
          flt_set[FLT_LINE] = 1'b1; // [R16]
        end
        if (flt_set != '0) begin
          next_state = ST_HALT; // [R11] [R12]
          next_gate  = 1'b0; // [R21]
        end
      end
      ST_HALT: begin
        // Stay biased; supply bleeds down and must recharge to start
        if (!sup_ok) begin
          next_state = ST_LOCK; // [R4] [R12]
        end
      end
      default: begin
        next_state = ST_LOCK;
      end
    endcase

    if (!en || !sup_ok) begin
      if (state != ST_HALT || !sup_ok) begin
        next_state = ST_LOCK; // [R5]
      end
      next_gate = 1'b0; // [R21]
    end

    // A fault raised in the clearing cycle survives
    next_fault = (fault & ~flt_clr) | flt_set;
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      state    <= ST_LOCK;
      mode     <= MD_CV;
      ss_cnt   <= '0;
      cyc_cnt  <= '0;
      on_cmd   <= '0;
      fb       <= '0;
      load_est <= '0;
      aux_seen <= 1'b0;
      aux_prev <= 1'b0;
      no_aux   <= '0;
      sup_ok   <= 1'b0;
      fault    <= '0;
      en       <= 1'b1;
      ref_lvl  <= FB_REF_DEF;
      GATE_DRV <= 1'b0;
      RD_DATA  <= '0;
    end else begin
      state    <= next_state;
      mode     <= next_mode;
      ss_cnt   <= next_ss_cnt;
      cyc_cnt  <= next_cyc_cnt;
      on_cmd   <= next_on_cmd;
      fb       <= next_fb;
      load_est <= next_load_est;
      aux_seen <= next_aux_seen;
      aux_prev <= next_aux_prev;
      no_aux   <= next_no_aux;
      sup_ok   <= next_sup_ok;
      fault    <= next_fault;
      en       <= next_en;
      ref_lvl  <= next_ref_lvl;
      GATE_DRV <= next_gate;
      RD_DATA  <= next_rd;
    end
  end
endmodule : fpm_seq_top

// ===== tb/fpm_seq_properties.sv
`timescale 1ns/100ps
module fpm_seq_properties #(
  parameter int SW_PERIOD  = fpm_pkg::SW_PER_CYC,
  parameter int PERIOD_MAX = fpm_pkg::PMAX_CYC
) (
  // Clock and reset
  input wire logic                   CLK,
  input wire logic                   RST_B,
  // Register port
  input wire logic [fpm_pkg::AW-1:0] ADDR,
  input wire logic [fpm_pkg::DW-1:0] WR_DATA,
  input wire logic                   WR_EN,
  input wire logic                   RD_EN,
  input wire logic [fpm_pkg::DW-1:0] RD_DATA,
  // Sense and drive
  input wire logic                   SUPPLY_LOW,
  input wire logic [fpm_pkg::VW-1:0] LINE_LVL,
  input wire logic                   AUX_CMP,
  input wire logic                   GATE_DRV
);
  import fpm_pkg::*;
  logic [15:0] since_rise;
  logic [15:0] next_since_rise;
  logic [15:0] high_len;
  logic [15:0] next_high_len;
  logic        knee_seen;
  logic        next_knee_seen;
  logic        gate_q;
  logic        aux_q;
  logic        bad_line;
  assign bad_line = (LINE_LVL < LINE_UV) || (LINE_LVL > LINE_OV);
  // Saturating so a first pulse after a long stop is never judged as a period
  always_comb begin
    next_since_rise = (since_rise == 16'hFFFF) ? since_rise : since_rise + 16'h1;
    next_high_len   = GATE_DRV ? high_len + 16'h1 : 16'h0;
    next_knee_seen  = knee_seen;
    if (!AUX_CMP && aux_q && !GATE_DRV) next_knee_seen = 1'b1;
    if (GATE_DRV && !gate_q) begin
      next_since_rise = 16'h1;
      next_knee_seen  = 1'b0;
    end
  end
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      since_rise <= 16'hFFFF;
      high_len   <= 16'h0;
      knee_seen  <= 1'b0;
      gate_q     <= 1'b0;
      aux_q      <= 1'b0;
    end else begin
      since_rise <= next_since_rise;
      high_len   <= next_high_len;
      knee_seen  <= next_knee_seen;
      gate_q     <= GATE_DRV;
      aux_q      <= AUX_CMP;
    end
  end
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_B);
  sequence s_ctrl_off;
    WR_EN && ADDR == REG_CTRL && !WR_DATA[CTRL_EN];
  endsequence
  sequence s_supply_gone;
    SUPPLY_LOW [*5];
  endsequence
  sequence s_line_bad;
    bad_line [*6];
  endsequence
  chk_read_one_cycle: assert property (!$past(RD_EN) |-> RD_DATA == '0)
    else $error("read data outside its cycle");
  chk_unmapped_zero: assert property (RD_EN && ADDR == 8'h20 |=> RD_DATA == '0)
    else $error("unmapped read not zero");
  chk_lockout_gate: assert property (s_supply_gone |-> !GATE_DRV)
    else $error("gate high in supply lockout");
  chk_disable_gate: assert property (s_ctrl_off |-> ##3 !GATE_DRV [*8])
    else $error("gate high while disabled");
  chk_line_guard: assert property (s_line_bad |=> !$rose(GATE_DRV))
    else $error("pulse with line out of range");
  chk_period_floor: assert property ($rose(GATE_DRV) |-> since_rise >= SW_PERIOD)
    else $error("switching period too short");
  chk_period_ceil: assert property ($rose(GATE_DRV) |-> since_rise <= PERIOD_MAX || since_rise > 2 * PERIOD_MAX)
    else $error("pulse after period limit");
  chk_knee_first: assert property ($rose(GATE_DRV) && since_rise <= PERIOD_MAX |-> knee_seen)
    else $error("pulse without aux knee");
  chk_on_time_cap: assert property (GATE_DRV |-> high_len < ON_MAX)
    else $error("on-time above maximum");
endmodule : fpm_seq_properties

bind fpm_seq_top fpm_seq_properties #(
  .SW_PERIOD (SW_PERIOD),
  .PERIOD_MAX(PERIOD_MAX)
) u_props (
  .CLK(CLK), .RST_B(RST_B), .ADDR(ADDR), .WR_DATA(WR_DATA), .WR_EN(WR_EN), .RD_EN(RD_EN),
  .RD_DATA(RD_DATA), .SUPPLY_LOW(SUPPLY_LOW), .LINE_LVL(LINE_LVL), .AUX_CMP(AUX_CMP),
  .GATE_DRV(GATE_DRV)
);

// ===== tb/fpm_xfmr_model.sv
`timescale 1ns/100ps
module fpm_xfmr_model (
  // Clock
  input  wire logic                   clk,
  // Switch side
  input  wire logic                   gate,
  // Test knobs
  input  wire logic                   knee_en,
  input  wire logic                   slow,
  input  wire logic [fpm_pkg::VW-1:0] lvl,
  // Aux winding
  output logic                        aux_cmp,
  output logic      [fpm_pkg::VW-1:0] aux_lvl
);
  import fpm_pkg::*;
  logic        gate_q = 1'b0;
  logic [11:0] cnt    = 12'h0;
  initial aux_cmp = 1'b0;
  initial aux_lvl = 10'h3FF;
  // Plateau outlasts the sample point; a slow knee stretches the off-time
  always @(posedge clk) begin
    gate_q <= gate;
    cnt    <= cnt + 12'h1;
    if (gate) begin
      aux_cmp <= 1'b0;
      aux_lvl <= ~aux_lvl;
    end else if (gate_q) begin
      aux_cmp <= 1'b1;
      aux_lvl <= lvl;
      cnt     <= 12'h1;
    end else if (aux_cmp && knee_en && cnt >= (slow ? 12'h2BC : 12'h0E6)) begin
      aux_cmp <= 1'b0;
      aux_lvl <= ~lvl;
    end
  end
endmodule : fpm_xfmr_model

// ===== tb/tb.sv
`timescale 1ns/100ps
module tb;
  import fpm_pkg::*;
  localparam int SW = 400;
  localparam int PM = 1200;
  logic          clk     = 1'b0;
  logic          rst_b   = 1'b0;
  logic [AW-1:0] addr    = '0;
  logic [DW-1:0] wr_data = '0;
  logic          wr_en   = 1'b0;
  logic          rd_en   = 1'b0;
  logic          s_start = 1'b0;
  logic          s_low   = 1'b0;
  logic          l_start = 1'b0;
  logic [VW-1:0] l_lvl   = LINE_NOM;
  logic [VW-1:0] fb      = 10'h180;
  logic          knee_en = 1'b1;
  logic          slow    = 1'b0;
  logic [DW-1:0] rd_data;
  logic [DW-1:0] d;
  logic [VW-1:0] aux_lvl;
  logic          aux_cmp;
  logic          gate;
  int            n_mismatch  = 0;
  int            check_count = 0;
  int            cyc         = 0;
  int            t0;
  initial begin
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;
  fpm_seq_top #(.SS1_LEN(50), .SS2_LEN(100), .SS3_LEN(200), .SW_PERIOD(SW), .PERIOD_MAX(PM)) dut_u (
    .CLK(clk), .RST_B(rst_b), .ADDR(addr), .WR_DATA(wr_data), .WR_EN(wr_en), .RD_EN(rd_en),
    .RD_DATA(rd_data), .SUPPLY_START(s_start), .SUPPLY_LOW(s_low), .LINE_START(l_start),
    .LINE_LVL(l_lvl), .AUX_LVL(aux_lvl), .AUX_CMP(aux_cmp), .GATE_DRV(gate));
  fpm_xfmr_model xf_u (.clk(clk), .gate(gate), .knee_en(knee_en), .slow(slow), .lvl(fb),
    .aux_cmp(aux_cmp), .aux_lvl(aux_lvl));
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : test_done
  task automatic chk(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] v);
    @(posedge clk);
    addr    <= a;
    wr_data <= v;
    wr_en   <= 1'b1;
    @(posedge clk);
    wr_en   <= 1'b0;
  endtask : wr
  // Data stand only in the cycle after the strobe
  task automatic rd(input logic [AW-1:0] a);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    @(negedge clk);
    d = rd_data;
  endtask : rd
  task automatic rchk(input logic [AW-1:0] a, input logic [DW-1:0] m, input logic [DW-1:0] e);
    rd(a);
    chk(d & m, e);
  endtask : rchk
  task automatic wait_st(input logic [3:0] st, input int lim);
    for (int i = 0; i < lim; i++) begin
      rd(REG_STAT);
      if (d[3:0] === st) return;
    end
    n_mismatch++;
    $display("MISMATCH t=%0t state %0h not reached", $time, st);
    test_done();
  endtask : wait_st
  // Long pause first so a restart is never mistaken for an overdue period
  task automatic recycle();
    repeat (2600) @(posedge clk);
    s_start <= 1'b0;
    s_low   <= 1'b1;
    wait_st(ST_LOCK, 20);
    @(posedge clk);
    s_low   <= 1'b0;
    s_start <= 1'b1;
  endtask : recycle
  initial begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    rchk(REG_CTRL, 32'h1, 32'h1);
    rchk(REG_REF, 32'h3FF, 32'h200);
    rchk(REG_STAT, 32'h18F, 32'h1);
    rchk(REG_FAULT, 32'h1F, 32'h0);
    wr(8'h20, 32'hFFFF_FFFF);
    rchk(8'h20, 32'hFFFF_FFFF, 32'h0);
    wr(REG_STAT, 32'h0);
    rchk(REG_STAT, 32'hF, 32'h1);
    $display("test reset_map done");
    @(posedge clk);
    s_start <= 1'b1;
    l_start <= 1'b1;
    l_lvl   <= LINE_UV - 10'h1;
    repeat (30) @(posedge clk);
    rchk(REG_STAT, 32'h18F, 32'h101);
    @(posedge clk);
    l_lvl <= LINE_NOM;
    wait_st(ST_SOFT, 10);
    t0 = cyc;
    rd(REG_ON);
    chk(32'(d[11:0] <= (ON_MAX >> SS1_SHR)), 32'h1);
    wait_st(ST_RUN, 1000);
    chk(32'(cyc - t0 >= 344 && cyc - t0 <= 350 + PM), 32'h1);
    rchk(REG_STAT, 32'h70, 32'({MD_CV, 4'h0}));
    repeat (4 * SW) @(posedge clk);
    rchk(REG_FB, 32'h3FF, 32'h180);
    @(posedge clk);
    slow <= 1'b1;
    repeat (3000) @(posedge clk);
    rchk(REG_STAT, 32'hF, 32'(ST_RUN));
    rchk(REG_FAULT, 32'h1F, 32'h0);
    @(posedge clk);
    slow <= 1'b0;
    fb   <= 10'h050;
    $display("test soft_start done");
    wait_st(ST_HALT, 1000);
    rchk(REG_FAULT, 32'h1, 32'h1);
    repeat (600) @(posedge clk);
    rchk(REG_STAT, 32'h8F, 32'(ST_HALT));
    wr(REG_FAULT, 32'h1F);
    rchk(REG_FAULT, 32'h1F, 32'h0);
    @(posedge clk);
    fb <= 10'h1D0;
    recycle();
    wait_st(ST_SOFT, 20);
    t0 = cyc;
    wait_st(ST_RUN, 200);
    chk(32'(cyc - t0 < 350), 32'h1);
    rchk(REG_STAT, 32'h70, 32'({MD_PFM, 4'h0}));
    $display("test collapse_pfm done");
    @(posedge clk);
    knee_en <= 1'b0;
    wait_st(ST_HALT, 1000);
    rchk(REG_FAULT, 32'h4, 32'h4);
    @(posedge clk);
    knee_en <= 1'b1;
    fb      <= 10'h180;
    recycle();
    wait_st(ST_RUN, 1000);
    @(posedge clk);
    l_lvl <= LINE_OV + 10'h1;
    wait_st(ST_HALT, 1000);
    rchk(REG_FAULT, 32'h8, 32'h8);
    @(posedge clk);
    l_lvl <= LINE_NOM;
    $display("test period_line done");
    recycle();
    wait_st(ST_RUN, 1000);
    wr(REG_CTRL, 32'h0);
    wait_st(ST_LOCK, 5);
    rchk(REG_STAT, 32'h80, 32'h0);
    repeat (2600) @(posedge clk);
    wr(REG_CTRL, 32'h1);
    wait_st(ST_RUN, 1000);
    @(posedge clk);
    s_low   <= 1'b1;
    s_start <= 1'b0;
    wait_st(ST_LOCK, 10);
    rchk(REG_STAT, 32'h180, 32'h0);
    $display("test enable_lockout done");
    // Matching target keeps on-time at one count, so only the aux guard can trip
    @(posedge clk);
    fb <= 10'h010;
    wr(REG_REF, 32'h010);
    recycle();
    wait_st(ST_RUN, 1000);
    t0 = cyc;
    wait_st(ST_HALT, 10000);
    chk(32'(cyc - t0 >= 2 * SW * 19), 32'h1);
    rchk(REG_FAULT, 32'h3, 32'h2);
    $display("test no_aux done");
    test_done();
  end
endmodule : tb
